// ==== pkg/flic_pkg.sv ====
package flic_pkg;
    // number of request sources, in fixed polling order
    localparam int NUM_SRC = 6;
    localparam int LVL_W = 2;
    localparam int NUM_LVL = 4;
    // polling order indices, first is polled first
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_SER = 4;
    localparam int SRC_TMR2 = 5;
    // vector addresses per source
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000B;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001B;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [15:0] VEC_TMR2 = 16'h002B;
    // machine cycle length in clocks and sample phase within it
    localparam int MC_CLKS = 12;
    localparam int SAMPLE_PHASE_IDX = 9;
    // highest level, never preempted
    localparam logic [1:0] TOP_LVL = 2'h3;

    // core status for the current machine cycle
    typedef struct packed {
        logic last_cycle;       // final cycle of the instruction in progress
        logic block_instr;      // handler return or enable/priority write in progress
        logic handler_exit;     // handler return completes (one pulse)
    } flic_core_t;

    // vectored call request to the core
    typedef struct packed {
        logic valid;
        logic [2:0] src;
        logic [15:0] addr;
        logic [1:0] level;
    } flic_call_t;
endpackage : flic_pkg

// ==== rtl/flic_ext_req.sv ====
`timescale 1ns/1ps
`default_nettype none
// one external request: pin sync, level or falling-transition flag
module flic_ext_req
    import flic_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic request_pin_n,
    input wire logic edge_select,
    input wire logic sample_phase,
    input wire logic vec_clear,
    input wire logic sw_set,
    input wire logic sw_clr,
    output logic request_flag
);
    logic sync1_q; // first stage, read only by second
    logic sync2_q;
    logic prev_q; // last sampled pin level
    logic flag_q;

    // two-stage synchroniser for the asynchronous pin
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= request_pin_n;
            sync2_q <= sync1_q;
        end
    end

    // flag update, sampled once per machine cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_q <= 1'b1;
            flag_q <= 1'b0;
        end
        else
        begin
            if (sample_phase)
                prev_q <= sync2_q;
            if (!edge_select && sample_phase)
                // level mode: flag mirrors the inverted pin at each sample
                flag_q <= !sync2_q;
            else if (edge_select && sample_phase && prev_q && !sync2_q)
                flag_q <= 1'b1; // high then low sample sets it, set wins
            else if (sw_set)
                flag_q <= 1'b1; // software raise; in level mode it lasts until the next sample
            else if (sw_clr || vec_clear)
                flag_q <= 1'b0; // cleared on vectoring only in edge mode
        end
    end

    assign request_flag = flag_q;
endmodule // flic_ext_req
`default_nettype wire

// ==== rtl/flic_sw_flag.sv ====
`timescale 1ns/1ps
`default_nettype none
// generic sticky flag: hardware set, software set/clear, vector clear
module flic_sw_flag
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_set,
    input wire logic sw_set,
    input wire logic sw_clr,
    input wire logic vec_clear,
    output logic flag
);
    logic flag_q;

    // a set in the same cycle as any clear wins so no event is lost
    always_ff @(posedge clk)
    begin
        if (rst)
            flag_q <= 1'b0;
        else if (hw_set || sw_set)
            flag_q <= 1'b1;
        else if (sw_clr || vec_clear)
            flag_q <= 1'b0;
    end

    assign flag = flag_q;
endmodule // flic_sw_flag
`default_nettype wire

// ==== rtl/flic_top.sv ====
// Overview of operation
// - six sources: two pins, three timers, serial
// - each pin selects level or transition mode
// - transition flags cleared when vectored to
// - level flag follows pin, not cleared on vectoring
// - timer 0/1 flags cleared on vectoring
// - serial request ORs rx/tx, never cleared
// - software set/clear equals hardware set/clear
// - per-source enables plus global disable
// - level from low and high priority bits
// - preempt only by strictly higher level
// - higher level wins in same poll
// - fixed order breaks ties within level
// - sample each cycle, poll at end of same cycle
// - block on in-service, mid-instruction, special instruction
// - two instructions run after blocking instruction
// - no memory of blocked requests
// - call pushes pc, not flags, loads vector
// - handler return clears current level in-service
// - plain return leaves in-service set
// - late higher request vectored before lower handler
// - level is high bit over low bit
// - low level or high-then-low sample requests
`timescale 1ns/1ps
`default_nettype none
module flic_top
    import flic_pkg::*;
#(
    parameter int MC_LEN = MC_CLKS // clocks per machine cycle
)
(
    input wire logic clk,
    input wire logic rst,
    // external request pins, active low, asynchronous
    input wire logic ext0_request_pin_n,
    input wire logic ext1_request_pin_n,
    // timer control bits selecting transition mode
    input wire logic ext0_edge_select,
    input wire logic ext1_edge_select,
    // rollover pulses from timers 0 and 1, and the timer 2 flags
    input wire logic timer0_rollover,
    input wire logic timer1_rollover,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    // serial done flags, kept and cleared by the serial port
    input wire logic rx_done_flag,
    input wire logic tx_done_flag,
    // software set/clear strobes for the four owned flags, order ext0,tmr0,ext1,tmr1
    input wire logic [3:0] flag_sw_set,
    input wire logic [3:0] flag_sw_clr,
    // enable and priority register contents
    input wire logic global_irq_enable,
    input wire logic [NUM_SRC-1:0] source_enable_reg,
    input wire logic [NUM_SRC-1:0] priority_low_reg,
    input wire logic [NUM_SRC-1:0] priority_high_reg,
    // core status in, call request and status out
    input wire flic_core_t core_status,
    output flic_call_t hw_vector_call,
    output logic machine_cycle_strobe,
    output logic [NUM_LVL-1:0] in_service,
    output logic [3:0] owned_flags
);
    logic [$clog2(MC_LEN)-1:0] phase_q; // clock within machine cycle, sized by the parameter
    logic sample_phase; // one-cycle pulse at the sample point
    logic cycle_end; // last clock of a machine cycle
    logic ext0_request_flag;
    logic ext1_request_flag;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic [NUM_SRC-1:0] vec_clr; // per-source clear on vectoring
    logic [NUM_SRC-1:0] req_now; // live request flags
    logic [NUM_SRC-1:0] sampled_q; // flags latched at the sample point
    logic [NUM_SRC-1:0] pend; // enabled sampled requests
    logic [LVL_W-1:0] lvl [NUM_SRC]; // level of each source
    logic found;
    logic [2:0] win_src;
    logic [LVL_W-1:0] win_lvl;
    logic [NUM_LVL-1:0] svc_q; // in-service bit per level
    logic [LVL_W-1:0] cur_lvl; // highest level in service
    logic any_svc;
    logic hold_q; // a blocking instruction just finished
    logic fire;
    flic_call_t call_q;
    logic [15:0] vec_addr;

    // machine cycle divider, one enable pulse per phase event
    always_ff @(posedge clk)
    begin
        if (rst)
            phase_q <= '0;
        else if (cycle_end)
            phase_q <= '0;
        else
            phase_q <= phase_q + 1'b1;
    end

    assign cycle_end = (phase_q == ($clog2(MC_LEN))'(MC_LEN - 1));
    assign sample_phase = (phase_q == ($clog2(MC_LEN))'(SAMPLE_PHASE_IDX));
    assign machine_cycle_strobe = cycle_end;

    // external request flag cells
    flic_ext_req u_ext0 (
        .clk(clk),
        .rst(rst),
        .request_pin_n(ext0_request_pin_n),
        .edge_select(ext0_edge_select),
        .sample_phase(sample_phase),
        .vec_clear(vec_clr[SRC_EXT0] & ext0_edge_select),
        .sw_set(flag_sw_set[0]),
        .sw_clr(flag_sw_clr[0]),
        .request_flag(ext0_request_flag)
    );

    flic_ext_req u_ext1 (
        .clk(clk),
        .rst(rst),
        .request_pin_n(ext1_request_pin_n),
        .edge_select(ext1_edge_select),
        .sample_phase(sample_phase),
        .vec_clear(vec_clr[SRC_EXT1] & ext1_edge_select),
        .sw_set(flag_sw_set[2]),
        .sw_clr(flag_sw_clr[2]),
        .request_flag(ext1_request_flag)
    );

    // timer 0 and 1 flags, cleared by the vectored call
    flic_sw_flag u_tf0 (
        .clk(clk),
        .rst(rst),
        .hw_set(timer0_rollover),
        .sw_set(flag_sw_set[1]),
        .sw_clr(flag_sw_clr[1]),
        .vec_clear(vec_clr[SRC_TMR0]),
        .flag(timer0_overflow_flag)
    );

    flic_sw_flag u_tf1 (
        .clk(clk),
        .rst(rst),
        .hw_set(timer1_rollover),
        .sw_set(flag_sw_set[3]),
        .sw_clr(flag_sw_clr[3]),
        .vec_clear(vec_clr[SRC_TMR1]),
        .flag(timer1_overflow_flag)
    );

    assign owned_flags = {timer1_overflow_flag, ext1_request_flag,
                          timer0_overflow_flag, ext0_request_flag};

    // six sources in polling order
    always_comb
    begin
        req_now = '0;
        req_now[SRC_EXT0] = ext0_request_flag;
        req_now[SRC_TMR0] = timer0_overflow_flag;
        req_now[SRC_EXT1] = ext1_request_flag;
        req_now[SRC_TMR1] = timer1_overflow_flag;
        req_now[SRC_SER] = rx_done_flag | tx_done_flag; // never cleared here
        req_now[SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;
    end

    // sample all flags once per machine cycle; no history kept beyond this
    always_ff @(posedge clk)
    begin
        if (rst)
            sampled_q <= '0;
        else if (sample_phase)
            sampled_q <= req_now;
    end

    // per-source level and enable gating
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_src
            assign lvl[gi] = {priority_high_reg[gi], priority_low_reg[gi]};
            assign pend[gi] = sampled_q[gi] & source_enable_reg[gi] & global_irq_enable;
        end
    endgenerate

    // pick highest level, then first in polling order
    always_comb
    begin
        found = 1'b0;
        win_src = '0;
        win_lvl = '0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            // strict compare keeps the earlier source on a tie
            if (pend[i] && (!found || lvl[i] > win_lvl))
            begin
                found = 1'b1;
                win_src = 3'(i);
                win_lvl = lvl[i];
            end
        end
    end

    // highest level currently in service
    always_comb
    begin
        any_svc = |svc_q;
        cur_lvl = '0;
        for (int l = 0; l < NUM_LVL; l++)
        begin
            if (svc_q[l])
                cur_lvl = LVL_W'(l);
        end
    end

    // a blocking instruction delays vectoring past the next instruction
    always_ff @(posedge clk)
    begin
        if (rst)
            hold_q <= 1'b0;
        else if (cycle_end && core_status.last_cycle)
            hold_q <= core_status.block_instr;
    end

    // poll at the end of the same machine cycle in which sampling happened
    // level 3 in service can never be exceeded, so it is never preempted
    assign fire = cycle_end && found && core_status.last_cycle
                  && !core_status.block_instr && !hold_q
                  && (!any_svc || win_lvl > cur_lvl);

    // request clear per source on the call cycle; serial and timer 2 never
    always_comb
    begin
        vec_clr = '0;
        if (fire && (win_src == 3'(SRC_EXT0) || win_src == 3'(SRC_TMR0) ||
                     win_src == 3'(SRC_EXT1) || win_src == 3'(SRC_TMR1)))
            vec_clr[win_src] = 1'b1;
    end

    // vector address by source
    always_comb
    begin
        case (win_src)
            3'(SRC_EXT0): vec_addr = VEC_EXT0;
            3'(SRC_TMR0): vec_addr = VEC_TMR0;
            3'(SRC_EXT1): vec_addr = VEC_EXT1;
            3'(SRC_TMR1): vec_addr = VEC_TMR1;
            3'(SRC_SER): vec_addr = VEC_SER;
            default: vec_addr = VEC_TMR2;
        endcase
    end

    // call request, one cycle pulse; core pushes pc only, not its flags word
    // a higher request sampled meanwhile fires at the next poll, ahead of the handler
    always_ff @(posedge clk)
    begin
        if (rst)
            call_q <= '0;
        else
        begin
            call_q.valid <= fire;
            if (fire)
            begin
                call_q.src <= win_src;
                call_q.addr <= vec_addr;
                call_q.level <= win_lvl;
            end
        end
    end

    assign hw_vector_call = call_q;

    // in-service bits: set by the call, cleared by handler return only
    always_ff @(posedge clk)
    begin
        if (rst)
            svc_q <= '0;
        else
        begin
            if (core_status.handler_exit && any_svc)
                svc_q[cur_lvl] <= 1'b0; // plain return has no input here
            if (fire)
                svc_q[win_lvl] <= 1'b1; // set wins over a same-cycle clear
        end
    end

    assign in_service = svc_q;
endmodule // flic_top
`default_nettype wire

// ==== bench/flic_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the vectored call and the in-service bits
module flic_checker
    import flic_pkg::*;
#(
    parameter int MC_LEN = MC_CLKS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic global_irq_enable,
    input wire logic [NUM_SRC-1:0] source_enable_reg,
    input wire logic [NUM_SRC-1:0] priority_low_reg,
    input wire logic [NUM_SRC-1:0] priority_high_reg,
    input wire flic_core_t core_status,
    input wire flic_call_t hw_vector_call,
    input wire logic machine_cycle_strobe,
    input wire logic [NUM_LVL-1:0] in_service,
    input wire logic [3:0] owned_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    flic_call_t c; // short alias for the call
    logic [5:0] en_q, pl_q, ph_q; // settings seen by the poll
    logic [3:0] is_q; // in-service before the call landed
    assign c = hw_vector_call;
    // one-clock-old copies, the call is registered off these
    always_ff @(posedge clk)
    begin
        en_q <= source_enable_reg & {6{global_irq_enable}};
        pl_q <= priority_low_reg;
        ph_q <= priority_high_reg;
        is_q <= in_service;
    end
    sequence s_call;
        c.valid;
    endsequence
    sequence s_quiet;
        !c.valid [*8];
    endsequence
    AST_ONE_PER_CYCLE: assert property (s_call |=> s_quiet)
        else $error("calls too close together");
    AST_POLL_EDGE: assert property (s_call |-> $past(machine_cycle_strobe && core_status.last_cycle))
        else $error("call not at an instruction end");
    AST_NOT_BLOCKED: assert property (s_call |-> !$past(core_status.block_instr))
        else $error("call during a blocking instruction");
    AST_ENABLED: assert property (s_call |-> en_q[c.src])
        else $error("call from a disabled source");
    AST_VECTOR: assert property (s_call |-> c.addr == {10'h000, c.src, 3'h3})
        else $error("wrong vector address");
    AST_LEVEL: assert property (s_call |-> c.level == {ph_q[c.src], pl_q[c.src]})
        else $error("wrong call level");
    AST_MARK_LEVEL: assert property (s_call |-> in_service[c.level])
        else $error("in-service bit not set");
    AST_PREEMPT: assert property (s_call |-> (is_q >> c.level) == 4'h0)
        else $error("call not above running level");
    AST_TMR_CLEAR: assert property (c.valid && c.src[0] && !c.src[2] |-> !owned_flags[c.src[1:0]])
        else $error("timer flag kept after call");
    AST_EXIT: assert property (core_status.handler_exit && in_service != 4'h0
        |=> $countones(in_service) < $countones(is_q) || c.valid)
        else $error("handler exit left level set");
endmodule // flic_checker
bind flic_top flic_checker #(.MC_LEN(MC_LEN)) u_chk (.clk(clk), .rst(rst),
    .global_irq_enable(global_irq_enable), .source_enable_reg(source_enable_reg),
    .priority_low_reg(priority_low_reg), .priority_high_reg(priority_high_reg),
    .core_status(core_status), .hw_vector_call(hw_vector_call),
    .machine_cycle_strobe(machine_cycle_strobe), .in_service(in_service),
    .owned_flags(owned_flags));
`default_nettype wire

// ==== bench/flic_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// core stand-in: instruction ends, blocking instructions, handler return
module flic_core_model
    import flic_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic blk,
    input wire logic ret_go,
    output flic_core_t core_status
);
    // stall models a long instruction, so no end-of-instruction poll
    always_ff @(posedge clk)
    begin
        if (rst)
            core_status <= '0;
        else
        begin
            core_status.last_cycle <= !stall;
            core_status.block_instr <= blk;
            core_status.handler_exit <= ret_go && !core_status.handler_exit;
        end
    end
endmodule // flic_core_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// directed bench for the interrupt controller
module tb import flic_pkg::*;;
    logic clk, rst, p0_n, p1_n, es0, es1, t0r, t1r, t2o, t2e, rxd, txd, gie, stall, blk, ret_go;
    logic [3:0] sws, swc, ins, own;
    logic [5:0] sen, pl, ph;
    flic_core_t cs;
    flic_call_t call;
    logic mcs;
    int fail_count, num_checks, cyc;
    flic_top u_dut (.clk(clk), .rst(rst), .ext0_request_pin_n(p0_n), .ext1_request_pin_n(p1_n),
        .ext0_edge_select(es0), .ext1_edge_select(es1), .timer0_rollover(t0r),
        .timer1_rollover(t1r), .timer2_overflow_flag(t2o), .timer2_external_flag(t2e),
        .rx_done_flag(rxd), .tx_done_flag(txd), .flag_sw_set(sws), .flag_sw_clr(swc),
        .global_irq_enable(gie), .source_enable_reg(sen), .priority_low_reg(pl),
        .priority_high_reg(ph), .core_status(cs), .hw_vector_call(call),
        .machine_cycle_strobe(mcs), .in_service(ins), .owned_flags(own));
    flic_core_model u_core (.clk(clk), .rst(rst), .stall(stall), .blk(blk), .ret_go(ret_go),
        .core_status(cs));
    always #2 clk = ~clk;
    // a hang is cut short here
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // waits a bounded time for a call and checks what it carries
    task automatic wait_call(logic [2:0] s, logic [1:0] l);
        int n;
        n = 0;
        while (call.valid !== 1'b1 && n < 60)
        begin
            step();
            n++;
        end
        chk({13'h0, call.src}, {13'h0, s}, "src");
        chk(call.addr, {10'h0, s, 3'h3}, "vector");
        chk({14'h0, call.level}, {14'h0, l}, "level");
        step();
    endtask
    task automatic no_call(int n);
        repeat (n)
        begin
            step();
            chk({15'h0, call.valid}, 16'h0, "unexpected call");
        end
    endtask
    task automatic ret();
        ret_go = 1;
        step();
        ret_go = 0;
        step(2);
    endtask
    task automatic swset(logic [3:0] m);
        sws = m;
        step();
        sws = 0;
    endtask
    initial
    begin
        {clk, t0r, t1r, t2o, t2e, rxd, txd, gie, stall, blk, ret_go} = '0;
        {rst, p0_n, p1_n, es0, es1} = '1;
        {sws, swc, pl, ph, fail_count, num_checks, cyc} = '0;
        sen = 6'h3F;
        repeat (10) @(posedge clk);
        #1 rst = 0;
        step();
        // everything pending while globally disabled
        swset(4'hF);
        rxd = 1;
        t2o = 1;
        no_call(36);
        gie = 1;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            wait_call(i[2:0], 2'h0);
            if (i < 4)
                chk({15'h0, own[i]}, 16'h0, "flag kept");
            if (i == 4)
            begin
                rxd = 0;
                txd = 1;
                ret();
                wait_call(3'h4, 2'h0);
                txd = 0;
            end
            if (i == 5)
            begin
                t2o = 0;
                t2e = 1;
                ret();
                wait_call(3'h5, 2'h0);
                t2e = 0;
            end
            ret();
        end
        no_call(36);
        chk({12'h0, ins}, 16'h0, "in service");
        // ext1 level 2, tmr0 level 1, tmr1 level 3, then ext0 also level 3; unused bits kept 0
        pl = 6'h0A;
        ph = 6'h0C;
        swset(4'h6);
        wait_call(3'h2, 2'h2);
        no_call(24);
        t1r = 1;
        step();
        t1r = 0;
        wait_call(3'h3, 2'h3);
        pl = 6'h0B;
        ph = 6'h0D;
        swset(4'h1);
        no_call(24);
        ret();
        wait_call(3'h0, 2'h3);
        ret();
        no_call(24);
        ret();
        wait_call(3'h1, 2'h1);
        ret();
        pl = 6'h00;
        ph = 6'h00;
        // instruction not at its end, then a blocking instruction
        stall = 1;
        swset(4'h2);
        no_call(36);
        stall = 0;
        wait_call(3'h1, 2'h0);
        ret();
        blk = 1;
        swset(4'h2);
        no_call(36);
        blk = 0;
        no_call(12);
        wait_call(3'h1, 2'h0);
        ret();
        blk = 1;
        swset(4'h2);
        no_call(36);
        swc = 4'h2;
        step();
        swc = 0;
        blk = 0;
        no_call(36);
        chk({12'h0, own}, 16'h0, "flags");
        // pins: falling transition on ext0, low level on ext1
        p0_n = 0;
        wait_call(3'h0, 2'h0);
        chk({15'h0, own[0]}, 16'h0, "edge flag");
        ret();
        p0_n = 1;
        es1 = 0;
        p1_n = 0;
        wait_call(3'h2, 2'h0);
        chk({15'h0, own[2]}, 16'h1, "level flag");
        p1_n = 1;
        step(36);
        chk({15'h0, own[2]}, 16'h0, "level flag");
        ret();
        no_call(24);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
